// >>> core/ascp_top.sv
// Function
// - select and data strap high pick reduced swing
// - select and clock strap high give fixed word
// - select high ignores clock and data pins
// - frame starts at select fall, then clock rise
// - 16-bit instruction then word-length data bytes
// - bits interpreted only while select low
// - select may stall between whole bytes, except in streaming where its rise ends the frame
// - word length 11 streams until select rises
// - select rise mid-byte resets serial state
// - select tied low runs two-wire from power-up
// - two-wire streaming cannot be left
// - instruction decides write or readback
// - readback turns data pin to output
// - bit order MSB first, LSB when configured
// - data sampled on serial clock rising edge
// - data pin turns around on falling edges, or at select fall after a stall
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module ascp_top #(
  parameter int DEPTH = 32
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_clock_or_pattern_strap_pin,
  input  wire logic        port_select_n,
  input  wire logic        data_io_or_driver_strap_pin_in,
  output logic             data_io_or_driver_strap_pin_out,
  output logic             data_io_or_driver_strap_pin_oe,
  output logic             reduced_swing_strap,
  output logic             fixed_pattern_strap,
  output logic      [13:0] pattern_word
);
  localparam int AW = ascp_pkg::ADDR_W;

  logic [2:0]  pins_sync;
  logic        sck_s;
  logic        sel_n_s;
  logic        din_s;
  logic        sck_prev_reg;
  logic        sck_rise;
  logic        sck_fall;

  ascp_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({serial_clock_or_pattern_strap_pin, port_select_n,
                data_io_or_driver_strap_pin_in}),
    .sync_out (pins_sync)
  );

  assign sck_s   = pins_sync[2];
  assign sel_n_s = pins_sync[1];
  assign din_s   = pins_sync[0];
  assign sck_rise = sck_s && !sck_prev_reg;
  assign sck_fall = !sck_s && sck_prev_reg;

  // Serial engine state
  ascp_pkg::ascp_state_e state_reg, state_next;
  logic [3:0]    bit_cnt_reg, bit_cnt_next;
  logic [15:0]   sr_reg, sr_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [1:0]    left_reg, left_next;
  logic          stream_reg, stream_next;
  logic          read_reg, read_next;
  logic          dout_reg, dout_next;
  logic          oe_reg, oe_next;
  logic          wr_reg, wr_next;
  logic [AW-1:0] waddr_reg, waddr_next;
  logic [7:0]    wdata_reg, wdata_next;
  logic [7:0]    spi_rdata;
  logic          lsb_first_reg;

  // Strap capture state
  logic [1:0]  strap_cnt_reg, strap_cnt_next;
  logic        swing_reg, swing_next;
  logic        patt_reg, patt_next;
  logic [13:0] pword_reg, pword_next;

  // APB state
  logic          lsb_next;
  logic [AW-1:0] index_reg, index_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic          pready_reg, pready_next;
  logic          pslverr_reg, pslverr_next;
  logic          apb_wr_data;
  logic          mapped;
  logic [7:0]    apb_rdata;

  ascp_regs #(
    .DEPTH (DEPTH)
  ) u_regs (
    .clk       (pclk),
    .rst_n     (presetn),
    .spi_wr    (wr_reg),
    .spi_waddr (waddr_reg),
    .spi_wdata (wdata_reg),
    .spi_raddr (addr_reg),
    .spi_rdata (spi_rdata),
    .apb_wr    (apb_wr_data),
    .apb_addr  (index_reg),
    .apb_wdata (pwdata[7:0]),
    .apb_rdata (apb_rdata)
  );

  // Serial frame decoder; nothing shifts while select is high
  always_comb begin
    state_next  = state_reg;
    bit_cnt_next = bit_cnt_reg;
    sr_next     = sr_reg;
    addr_next   = addr_reg;
    left_next   = left_reg;
    stream_next = stream_reg;
    read_next   = read_reg;
    dout_next   = dout_reg;
    oe_next     = oe_reg;
    wr_next     = 1'b0;
    waddr_next  = waddr_reg;
    wdata_next  = wdata_reg;
    if (sel_n_s) begin
      oe_next = 1'b0;
      if (bit_cnt_reg[2:0] != 3'h0) begin
        state_next = ascp_pkg::ASCP_IDLE;
      end else if (state_reg == ascp_pkg::ASCP_DATA && stream_reg) begin
        state_next = ascp_pkg::ASCP_IDLE;
      end else if (state_reg == ascp_pkg::ASCP_INSTR && bit_cnt_reg == 4'h0) begin
        state_next = ascp_pkg::ASCP_IDLE;
      end
      // Otherwise a stall between whole bytes keeps the frame
      if (state_next == ascp_pkg::ASCP_IDLE) begin
        bit_cnt_next = 4'h0;
        stream_next  = 1'b0;
      end
    end else begin
      case (state_reg)
        ascp_pkg::ASCP_IDLE: begin
          // Select low after reset also covers the two-wire power-up
          state_next   = ascp_pkg::ASCP_INSTR;
          bit_cnt_next = 4'h0;
        end
        ascp_pkg::ASCP_INSTR: begin
          if (sck_fall) begin
            oe_next = 1'b0;
          end
          if (sck_rise) begin
            sr_next = lsb_first_reg ? {din_s, sr_reg[15:1]}
                                    : {sr_reg[14:0], din_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == ascp_pkg::INSTR_LAST) begin
              state_next   = ascp_pkg::ASCP_DATA;
              bit_cnt_next = 4'h0;
              read_next    = sr_next[ascp_pkg::INSTR_RW_POS];
              left_next    = sr_next[ascp_pkg::INSTR_WL_HI:ascp_pkg::INSTR_WL_LO];
              stream_next  = left_next == ascp_pkg::WL_STREAM;
              addr_next    = sr_next[AW-1:0];
            end
          end
        end
        ascp_pkg::ASCP_DATA: begin
          if (sck_fall || (!sck_s && !oe_reg)) begin
            oe_next   = read_reg;
            dout_next = lsb_first_reg ? spi_rdata[bit_cnt_reg[2:0]]
                                      : spi_rdata[3'h7 - bit_cnt_reg[2:0]];
          end
          if (sck_rise) begin
            sr_next = lsb_first_reg ? {din_s, sr_reg[15:1]}
                                    : {sr_reg[14:0], din_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg[2:0] == ascp_pkg::BYTE_LAST) begin
              bit_cnt_next = 4'h0;
              if (!read_reg) begin
                wr_next    = 1'b1;
                waddr_next = addr_reg;
                wdata_next = lsb_first_reg ? sr_next[15:8] : sr_next[7:0];
              end
              // Decrement for MSB first, increment for LSB first
              addr_next = lsb_first_reg ? addr_reg + 13'h0001
                                        : addr_reg - 13'h0001;
              if (!stream_reg) begin
                if (left_reg == 2'h0) begin
                  state_next = ascp_pkg::ASCP_INSTR;
                end else begin
                  left_next = left_reg - 2'h1;
                end
              end
            end
          end
        end
        default: begin
          state_next = ascp_pkg::ASCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_reg <= 1'b0;
      state_reg    <= ascp_pkg::ASCP_IDLE;
      bit_cnt_reg  <= 4'h0;
      sr_reg       <= 16'h0000;
      addr_reg     <= 13'h0000;
      left_reg     <= 2'h0;
      stream_reg   <= 1'b0;
      read_reg     <= 1'b0;
      dout_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      wr_reg       <= 1'b0;
      waddr_reg    <= 13'h0000;
      wdata_reg    <= 8'h00;
    end else begin
      sck_prev_reg <= sck_s;
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      sr_reg       <= sr_next;
      addr_reg     <= addr_next;
      left_reg     <= left_next;
      stream_reg   <= stream_next;
      read_reg     <= read_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      wr_reg       <= wr_next;
      waddr_reg    <= waddr_next;
      wdata_reg    <= wdata_next;
    end
  end

  // Straps caught once, after the synchroniser has settled
  always_comb begin
    strap_cnt_next = strap_cnt_reg;
    swing_next     = swing_reg;
    patt_next      = patt_reg;
    pword_next     = pword_reg;
    if (strap_cnt_reg != ascp_pkg::STRAP_WAIT) begin
      strap_cnt_next = strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == ascp_pkg::STRAP_WAIT - 2'h1) begin
        swing_next = sel_n_s && din_s;
        patt_next  = sel_n_s && sck_s;
        pword_next = (sel_n_s && sck_s) ? ascp_pkg::FIXED_PATTERN : 14'h0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg <= 2'h0;
      swing_reg     <= 1'b0;
      patt_reg      <= 1'b0;
      pword_reg     <= 14'h0000;
    end else begin
      strap_cnt_reg <= strap_cnt_next;
      swing_reg     <= swing_next;
      patt_reg      <= patt_next;
      pword_reg     <= pword_next;
    end
  end

  // APB slave, one wait state; a serial write due next cycle delays it
  assign mapped = paddr == ascp_pkg::OFS_CTRL || paddr == ascp_pkg::OFS_STATUS ||
                  paddr == ascp_pkg::OFS_INDEX || paddr == ascp_pkg::OFS_DATA;
  assign apb_wr_data = psel && penable && pready_reg && pwrite &&
                       paddr == ascp_pkg::OFS_DATA;

  always_comb begin
    lsb_next     = lsb_first_reg;
    index_next   = index_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel && penable && !pready_reg && !wr_next;
    pslverr_next = 1'b0;
    if (pready_next) begin
      pslverr_next = !mapped;
      prdata_next  = 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          ascp_pkg::OFS_CTRL: begin
            prdata_next[ascp_pkg::CTRL_LSB_POS] = lsb_first_reg;
          end
          ascp_pkg::OFS_STATUS: begin
            prdata_next[ascp_pkg::ST_SWING_POS]  = swing_reg;
            prdata_next[ascp_pkg::ST_PATT_POS]   = patt_reg;
            prdata_next[ascp_pkg::ST_ACTIVE_POS] = state_reg == ascp_pkg::ASCP_DATA;
            prdata_next[ascp_pkg::ST_STREAM_POS] = stream_reg;
            prdata_next[ascp_pkg::ST_READ_POS]   = read_reg;
          end
          ascp_pkg::OFS_INDEX: begin
            prdata_next[AW-1:0] = index_reg;
          end
          ascp_pkg::OFS_DATA: begin
            prdata_next[7:0] = apb_rdata;
          end
          default: begin
            prdata_next = 32'h00000000;
          end
        endcase
      end
    end
    if (psel && penable && pready_reg && pwrite) begin
      if (paddr == ascp_pkg::OFS_CTRL) begin
        lsb_next = pwdata[ascp_pkg::CTRL_LSB_POS];
      end
      if (paddr == ascp_pkg::OFS_INDEX) begin
        index_next = pwdata[AW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_first_reg <= ascp_pkg::CTRL_LSB_RST;
      index_reg     <= ascp_pkg::INDEX_RST;
      prdata_reg    <= 32'h00000000;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      lsb_first_reg <= lsb_next;
      index_reg     <= index_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign data_io_or_driver_strap_pin_out = dout_reg;
  assign data_io_or_driver_strap_pin_oe  = oe_reg;
  assign reduced_swing_strap = swing_reg;
  assign fixed_pattern_strap = patt_reg;
  assign pattern_word        = pword_reg;
endmodule // ascp_top

// >>> core/ascp_pkg.sv
package ascp_pkg;
  // Serial frame layout
  localparam int          INSTR_BITS    = 16;
  localparam int          BYTE_BITS     = 8;
  localparam int          ADDR_W        = 13;
  localparam int          INSTR_RW_POS  = 15;
  localparam int          INSTR_WL_HI   = 14;
  localparam int          INSTR_WL_LO   = 13;
  localparam logic [1:0]  WL_STREAM     = 2'h3;
  localparam logic [3:0]  INSTR_LAST    = 4'hF;
  localparam logic [2:0]  BYTE_LAST     = 3'h7;
  // Fixed output pattern caught from the clock strap
  localparam int          PATTERN_W     = 14;
  localparam logic [13:0] FIXED_PATTERN = 14'h2000;
  // Cycles after reset release before the straps are caught
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;
  // APB register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_INDEX     = 8'h08;
  localparam logic [7:0]  OFS_DATA      = 8'h0C;
  // Field positions and reset values
  localparam int          CTRL_LSB_POS  = 0;
  localparam int          ST_SWING_POS  = 0;
  localparam int          ST_PATT_POS   = 1;
  localparam int          ST_ACTIVE_POS = 2;
  localparam int          ST_STREAM_POS = 3;
  localparam int          ST_READ_POS   = 4;
  localparam logic        CTRL_LSB_RST  = 1'h0;
  localparam logic [12:0] INDEX_RST     = 13'h0000;

  typedef enum logic [1:0] {
    ASCP_IDLE  = 2'h0,
    ASCP_INSTR = 2'h1,
    ASCP_DATA  = 2'h2
  } ascp_state_e;
endpackage

// >>> core/ascp_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for asynchronous pin levels
module ascp_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("ascp_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // ascp_sync

// >>> core/ascp_regs.sv
`timescale 1ns/10ps
// Byte array reached by the serial port and by APB
module ascp_regs #(
  parameter int DEPTH = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        spi_wr,
  input  wire logic [12:0] spi_waddr,
  input  wire logic [7:0]  spi_wdata,
  input  wire logic [12:0] spi_raddr,
  output logic      [7:0]  spi_rdata,
  input  wire logic        apb_wr,
  input  wire logic [12:0] apb_addr,
  input  wire logic [7:0]  apb_wdata,
  output logic      [7:0]  apb_rdata
);
  logic [7:0] mem [DEPTH];

  generate
    if (DEPTH < 1 || DEPTH > 8192) begin : g_bad_depth
      $error("ascp_regs: DEPTH must be 1 to 8192");
    end
  endgenerate

  // Serial writes win; the APB side is stalled by the caller on collision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (spi_wr && int'(spi_waddr) < DEPTH) begin
      mem[int'(spi_waddr)] <= spi_wdata;
    end else if (apb_wr && int'(apb_addr) < DEPTH) begin
      mem[int'(apb_addr)] <= apb_wdata;
    end
  end

  // Unbacked addresses read as zero
  always_comb begin
    spi_rdata = 8'h00;
    apb_rdata = 8'h00;
    if (int'(spi_raddr) < DEPTH) begin
      spi_rdata = mem[int'(spi_raddr)];
    end
    if (int'(apb_addr) < DEPTH) begin
      apb_rdata = mem[int'(apb_addr)];
    end
  end
endmodule // ascp_regs

// >>> sim/ascp_props.sv
`timescale 1ns/10ps
// Watches the APB answer, strap capture and data pin turnaround
module ascp_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        port_select_n,
  input wire logic        data_io_or_driver_strap_pin_in,
  input wire logic        serial_clock_or_pattern_strap_pin,
  input wire logic        data_io_or_driver_strap_pin_oe,
  input wire logic        reduced_swing_strap,
  input wire logic        fixed_pattern_strap,
  input wire logic [13:0] pattern_word
);
  logic [2:0] up_reg;
  logic [2:0] up_next;
  logic       swing_pin;
  logic       patt_pin;
  // Strap pins as the device should see them
  assign swing_pin = port_select_n & data_io_or_driver_strap_pin_in;
  assign patt_pin  = port_select_n & serial_clock_or_pattern_strap_pin;
  // Edges since reset release, saturating so it never wraps
  always_comb begin
    up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_reg <= 3'h0;
    end else begin
      up_reg <= up_next;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  swing_capture_a: assert property (
    up_reg == 3'h6 |-> reduced_swing_strap == $past(swing_pin, 5))
    else $error("swing strap not taken from pins");
  pattern_capture_a: assert property (
    up_reg == 3'h6 |-> fixed_pattern_strap == $past(patt_pin, 5))
    else $error("pattern strap not taken from pins");
  straps_hold_a: assert property (
    up_reg == 3'h7 |-> $stable(reduced_swing_strap) && $stable(fixed_pattern_strap))
    else $error("strap result moved after capture");
  pattern_word_a: assert property (
    pattern_word == (fixed_pattern_strap ? ascp_pkg::FIXED_PATTERN : 14'h0000))
    else $error("pattern word wrong");
  oe_idle_a: assert property (
    port_select_n [*6] |-> !data_io_or_driver_strap_pin_oe)
    else $error("data pin driven while deselected");
  oe_select_a: assert property (
    $rose(data_io_or_driver_strap_pin_oe) |-> !port_select_n)
    else $error("data pin turned without select");
  pready_sel_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  pready_bound_a: assert property (psel && penable && !pready |-> ##[1:3] pready)
    else $error("ready late");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("error answer malformed");
endmodule // ascp_props

bind ascp_top ascp_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_select_n(port_select_n),
  .data_io_or_driver_strap_pin_in(data_io_or_driver_strap_pin_in),
  .serial_clock_or_pattern_strap_pin(serial_clock_or_pattern_strap_pin),
  .data_io_or_driver_strap_pin_oe(data_io_or_driver_strap_pin_oe),
  .reduced_swing_strap(reduced_swing_strap), .fixed_pattern_strap(fixed_pattern_strap),
  .pattern_word(pattern_word));

// >>> sim/ascp_host_model.sv
`timescale 1ns/10ps
// Serial master: clock idles low, stands still between frames
module ascp_host_model (
  input  wire logic pclk,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      sclk,
  output logic      sel_n,
  output logic      line
);
  logic drv_en;
  logic drv_val;
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    drv_en = 1'b1;
    drv_val = 1'b0;
  end
  // Released wire falls to the internal pull-down
  assign line = dev_oe ? dev_out : (drv_en & drv_val);
  // Strap levels held on the pins across reset
  task pins(input logic s, input logic c, input logic d);
    sel_n <= s;
    sclk <= c;
    drv_en <= 1'b1;
    drv_val <= d;
  endtask
  task start();
    @(posedge pclk) sclk <= 1'b0;
    sel_n <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task stop(input logic keep_low);
    @(posedge pclk) sclk <= 1'b0;
    repeat (4) @(posedge pclk);
    sel_n <= keep_low;
    drv_en <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  // One bit per clock period, data set up on the fall
  task shift(input logic [15:0] v, input int n, input logic lsb, input logic drv,
             output logic [15:0] got);
    int idx;
    got = 16'h0000;
    for (int k = 0; k < n; k++) begin
      idx = lsb ? k : n - 1 - k;
      @(posedge pclk) sclk <= 1'b0;
      drv_en <= drv;
      drv_val <= v[idx];
      repeat (3) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      @(negedge pclk) got[idx] = line;
    end
  endtask
endmodule // ascp_host_model

// >>> sim/adc_serial_config_port_tb_top.sv
`timescale 1ns/10ps
module adc_serial_config_port_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        sel_n;
  logic        line;
  logic        dout;
  logic        doe;
  logic        swing;
  logic        fixed;
  logic [13:0] pword;
  logic        lsb = 1'b0;
  logic        tw = 1'b0;
  logic [31:0] rd;
  logic        er;
  logic [23:0] sr;
  logic [15:0] g;
  int          fail_count = 0;
  int          total_checks = 0;

  initial begin
    forever #4 pclk = ~pclk;
  end

  ascp_top #(.DEPTH(32)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_or_pattern_strap_pin(sclk), .port_select_n(sel_n),
    .data_io_or_driver_strap_pin_in(line), .data_io_or_driver_strap_pin_out(dout),
    .data_io_or_driver_strap_pin_oe(doe), .reduced_swing_strap(swing),
    .fixed_pattern_strap(fixed), .pattern_word(pword));

  ascp_host_model host (
    .pclk(pclk), .dev_out(dout), .dev_oe(doe), .sclk(sclk), .sel_n(sel_n), .line(line));

  task give_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task aw(input logic [12:0] a, input logic [7:0] d);
    apb(1'b1, ascp_pkg::OFS_INDEX, {19'h00000, a});
    apb(1'b1, ascp_pkg::OFS_DATA, {24'h000000, d});
  endtask

  task ar(input logic [12:0] a, input logic [7:0] e);
    apb(1'b1, ascp_pkg::OFS_INDEX, {19'h00000, a});
    apb(1'b0, ascp_pkg::OFS_DATA, 32'h00000000);
    check("array byte", rd, {24'h000000, e});
  endtask

  // One frame; optional select stall between whole bytes
  task ser(input logic [15:0] i, input int nb, input logic [23:0] wd, input bit st);
    sr = 24'h000000;
    if (!tw) host.start();
    host.shift(i, 16, lsb, 1'b1, g);
    for (int b = 0; b < nb; b++) begin
      if (st && b > 0) begin
        host.stop(1'b1);
        host.start();
      end
      host.shift({8'h00, wd[8*b+:8]}, 8, lsb, !i[15], g);
      sr[8*b+:8] = g[7:0];
    end
    host.stop(!tw);
  endtask

  task do_reset(input logic s, input logic c, input logic d);
    @(posedge pclk);
    host.pins(s, c, d);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask

  task t_straps();
    do_reset(1'b1, 1'b1, 1'b1);
    check("swing", {30'h0, fixed, swing}, 32'h00000003);
    check("pattern", {18'h00000, pword}, 32'h00002000);
    apb(1'b0, ascp_pkg::OFS_STATUS, 32'h00000000);
    check("status", rd, 32'h00000003);
    do_reset(1'b1, 1'b0, 1'b0);
    check("swing off", {30'h0, fixed, swing}, 32'h00000000);
    aw(13'h0007, 8'h11);
    host.shift(16'h0007, 16, 1'b0, 1'b1, g);
    host.shift(16'h00EE, 8, 1'b0, 1'b1, g);
    repeat (8) @(posedge pclk);
    ar(13'h0007, 8'h11);
    check("straps kept", {30'h0, fixed, swing}, 32'h00000000);
  endtask

  task t_apb();
    apb(1'b0, ascp_pkg::OFS_CTRL, 32'h00000000);
    check("ctrl reset", rd, 32'h00000000);
    apb(1'b0, 8'h10, 32'h00000000);
    check("unmapped", {31'h0, er}, 32'h00000001);
  endtask

  task t_basic();
    aw(13'h0003, 8'hA5);
    ser(16'h8003, 1, 24'h000000, 1'b0);
    check("readback", {24'h0, sr[7:0]}, 32'h000000A5);
    ser(16'h0006, 1, 24'h00003C, 1'b0);
    ar(13'h0006, 8'h3C);
    // Three-byte write and two-byte read, both stalled between bytes
    ser(16'h4018, 3, 24'hD3D2D1, 1'b1);
    ar(13'h0018, 8'hD1);
    ar(13'h0016, 8'hD3);
    ser(16'hA018, 2, 24'h000000, 1'b1);
    check("stall read", {16'h0, sr[15:0]}, 32'h0000D2D1);
  endtask

  task t_stall_abort();
    ser(16'h200A, 2, 24'h00B2B1, 1'b1);
    ar(13'h000A, 8'hB1);
    ar(13'h0009, 8'hB2);
    aw(13'h000C, 8'h00);
    host.start();
    host.shift(16'h000C, 16, 1'b0, 1'b1, g);
    host.shift(16'h00FF, 4, 1'b0, 1'b1, g);
    host.stop(1'b1);
    ser(16'h000D, 1, 24'h000077, 1'b0);
    ar(13'h000C, 8'h00);
    ar(13'h000D, 8'h77);
  endtask

  task t_stream();
    ser(16'h6014, 3, 24'hC3C2C1, 1'b0);
    ar(13'h0014, 8'hC1);
    ar(13'h0012, 8'hC3);
    ser(16'hE014, 2, 24'h000000, 1'b0);
    check("stream read", {16'h0, sr[15:0]}, 32'h0000C2C1);
  endtask

  task t_lsb();
    apb(1'b1, ascp_pkg::OFS_CTRL, 32'h00000001);
    lsb = 1'b1;
    ser(16'h2004, 2, 24'h006996, 1'b0);
    ar(13'h0004, 8'h96);
    ar(13'h0005, 8'h69);
    ser(16'h8005, 1, 24'h000000, 1'b0);
    check("lsb read", {24'h0, sr[7:0]}, 32'h00000069);
    apb(1'b1, ascp_pkg::OFS_CTRL, 32'h00000000);
    lsb = 1'b0;
  endtask

  // Select held low from reset; host keeps to single bytes
  task t_two_wire();
    tw = 1'b1;
    do_reset(1'b0, 1'b0, 1'b0);
    aw(13'h0002, 8'h5A);
    ser(16'h8002, 1, 24'h000000, 1'b0);
    check("two wire read", {24'h0, sr[7:0]}, 32'h0000005A);
    ser(16'h0002, 1, 24'h0000A7, 1'b0);
    ar(13'h0002, 8'hA7);
  endtask

  initial begin
    t_straps();
    t_apb();
    t_basic();
    t_stall_abort();
    t_stream();
    t_lsb();
    t_two_wire();
    give_verdict();
  end

  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
endmodule // adc_serial_config_port_tb_top
